// ### logic/pllcg_defines.vh
// Constants for the loop clock generator control block.
// Assumes inclusion by bare name from the logic/ folder.
`ifndef PLLCG_DEFINES_VH
`define PLLCG_DEFINES_VH
// ***********************************
// Register indices (byte addr = 4*idx)
// ***********************************
`define PLLCG_IDX_SYNTH 6'h14
`define PLLCG_IDX_REFDV 6'h15
`define PLLCG_IDX_POST  6'h16
`define PLLCG_IDX_FLAGS 6'h17
`define PLLCG_IDX_INTEN 6'h18
`define PLLCG_IDX_CLKS  6'h19
`define PLLCG_IDX_OSC   6'h1a
`define PLLCG_IDX_GUARD 6'h1b
`define PLLCG_IDX_OSC2  6'h1e
// ***********************************
// Field positions
// ***********************************
`define PLLCG_B_MONRST  1
`define PLLCG_B_SWING   0
`define PLLCG_B_LSTAT   3
`define PLLCG_B_LFLAG   4
`define PLLCG_B_LOCK_CHANGE_IRQ_EN  4
`define PLLCG_B_OSC_CHANGE_IRQ_EN   1
`define PLLCG_B_LOOPSEL 7
`define PLLCG_B_GATING  0
`define PLLCG_B_OSCEN   7
// ***********************************
// Reset values and constants
// ***********************************
`define PLLCG_SYN_RST   6'h18
`define PLLCG_POST_RST  5'h03
`define PLLCG_VRNG_RST  2'h1
`define PLLCG_UNL_DIV   5'h03
`define PLLCG_GUARD_KEY 8'h26
`define PLLCG_PER_RST   16'h0010
`define PLLCG_PER_MIN   16'h0001
`define PLLCG_PER_MAX   16'hffff
`define PLLCG_FLOOR_LO  12'hfff
`endif

// ### logic/pllcg_divider.v
// Programmable tick divider: one output pulse per div+1 input ticks.
// Assumes tick_in is a one-cycle pulse on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module pllcg_divider #(
   parameter W = 4
) (
   // Clock and reset
   input  wire         clk_sys,
   input  wire         sys_rst,
   // Ticks
   input  wire         tick_in,
   input  wire [W-1:0] div,
   output reg          tick_out
);
   reg [W-1:0] cnt_r;
   // ***********************************
   // Counter
   // ***********************************
   // Shrinking div mid-count ends the period at once
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_r    <= {W{1'b0}};
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in) begin
            if (cnt_r >= div) begin
               cnt_r    <= {W{1'b0}};
               tick_out <= 1'b1;
            end else begin
               cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // pllcg_divider
`default_nettype wire

// ### logic/pllcg_lockdet.v
// Lock detector: counts feedback edges over a window of reference ticks.
// Assumes single-cycle tick inputs on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module pllcg_lockdet #(
   parameter [7:0]  WIN  = 8'h08,
   parameter [7:0]  TOL  = 8'h01,
   parameter [7:0]  UTOL = 8'h03,
   parameter [15:0] LOSS = 16'h0400
) (
   // Clock and reset
   input  wire clk_sys,
   input  wire sys_rst,
   // Ticks
   input  wire ref_tick,
   input  wire fb_edge,
   // Status
   output reg  locked,
   output reg  ref_lost
);
   reg [7:0]  win_r;
   reg [7:0]  fbc_r;
   reg [15:0] idle_r;
   wire [7:0] fbc_now = fbc_r + {7'h00, fb_edge};
   wire [7:0] dif = (fbc_now > WIN) ? fbc_now - WIN : WIN - fbc_now;
   // ***********************************
   // Window compare with hysteresis
   // ***********************************
   // Speed follows the reference rate
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         win_r    <= 8'h00;
         fbc_r    <= 8'h00;
         idle_r   <= 16'h0000;
         locked   <= 1'b0;
         ref_lost <= 1'b0;
      end else begin
         if (ref_tick) begin
            idle_r   <= 16'h0000;
            ref_lost <= 1'b0;
         end else if (idle_r >= LOSS) begin
            ref_lost <= 1'b1;
         end else begin
            idle_r <= idle_r + 16'h0001;
         end
         if (ref_lost) begin
            locked <= 1'b0;
            win_r  <= 8'h00;
            fbc_r  <= 8'h00;
         end else if (ref_tick && win_r >= WIN - 8'h01) begin
            win_r <= 8'h00;
            fbc_r <= 8'h00;
            // Narrow band to lock, wider band to drop
            if (dif <= TOL)
               locked <= 1'b1;
            else if (dif > UTOL)
               locked <= 1'b0;
         end else begin
            win_r <= win_r + {7'h00, ref_tick};
            fbc_r <= fbc_now;
         end
      end
   end
endmodule // pllcg_lockdet
`default_nettype wire

// ### logic/pllcg_top.v
// Loop clock generator control: registers, reference select,
// digital VCO model, phase detector and clock dividers.
// Assumes an Avalon-MM master on clk_sys and slow clock pins
// (below clk_sys/2) that are sampled, not used as clocks.
//
// Summary of operation
// - Osc2 writes need guard clear, loop select
// - Osc2 bit1 monitor reset, frozen while osc on
// - Osc2 bit0 swing mode, frozen while osc on
// - Reference is internal, or crystal over div+1
// - VCO runs 2*(synth+1) times reference
// - Locked: output is VCO over post+1
// - Unlocked: output is VCO over four
// - Bus clock is half the loop output, or half the crystal when loop select is clear
// - Phase detector compares feedback with reference
// - Lock judged by frequency compare, needs reference
// - Lock status read-only with hysteresis
// - Lock toggle raises interrupt when enabled
// - Reference loss drops VCO to range floor
// - Gating bit may delay watchdog after stop
// - Reset: internal ref, synth 0x18, post 0x03
// - Osc enable with Osc2 bit1 arms monitor; failure gives reset
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "pllcg_defines.vh"
module pllcg_top #(
   parameter [7:0]  LOCK_WIN  = 8'h08,
   parameter [7:0]  LOCK_TOL  = 8'h01,
   parameter [7:0]  UNL_TOL   = 8'h03,
   parameter [15:0] REF_LOSS  = 16'h0400
) (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        sys_rst,
   // Avalon-MM slave
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // Clock pins
   input  wire        internal_trimmed_clock,
   input  wire        crystal_clock,
   input  wire        osc_fail,
   // Generated clocks
   output reg         loop_output_clock,
   output reg         bus_clock,
   output reg         reference_clock,
   output reg         feedback_clock,
   // Oscillator and system controls
   output reg         ext_osc_enable,
   output reg         osc_swing_select,
   output reg         osc_monitor_reset_en,
   output reg         osc_monitor_reset,
   output reg         stop_clock_gating,
   output reg         lock_irq
);
   // ***********************************
   // Declarations
   // ***********************************
   reg  [1:0]  irc_s_r, xtl_s_r, fail_s_r;
   reg         irc_d_r, xtl_d_r;
   reg  [5:0]  synth_r;
   reg  [1:0]  vco_rng_r;
   reg  [3:0]  ref_div_r;
   reg  [1:0]  ref_rng_r;
   reg  [4:0]  post_r;
   reg         lflag_r, lock_ie_r, osc_ie_r, loop_sel_r, guard_r, lock_d_r;
   reg  [15:0] per_r, per_nxt, vcnt_r;
   reg         vco_tick_r, fb_half_r, ref_pend_r, fb_pend_r;
   reg  [31:0] rdata_nxt;
   wire        irc_rise = irc_s_r[1] & ~irc_d_r;
   wire        xtl_rise = xtl_s_r[1] & ~xtl_d_r;
   wire        src_tick, ref_tick, fb_tick, pll_tick, locked, ref_lost;
   wire        req = (avs_read | avs_write) & avs_waitrequest;
   wire        wr = avs_write & req & avs_byteenable[0];
   wire [5:0]  idx = avs_address[7:2];
   wire [7:0]  wd = avs_writedata[7:0];
   wire        open_wr = wr & ~guard_r;
   wire        fb_edge = fb_tick & ~fb_half_r;
   wire        corr_up = ref_tick & ~fb_edge & ~fb_pend_r;
   wire        corr_dn = fb_edge & ~ref_tick & ~ref_pend_r;
   wire        lock_chg = locked ^ lock_d_r;

   // Slowest period for the chosen VCO range
   function [15:0] vco_floor;
      input [1:0] rng;
      begin
         vco_floor = {2'b11, ~rng, `PLLCG_FLOOR_LO};
      end
   endfunction

   // ***********************************
   // Pin synchronisers
   // ***********************************
   // Edge detect looks at the second stage only
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         irc_s_r  <= 2'b00;
         xtl_s_r  <= 2'b00;
         fail_s_r <= 2'b00;
         irc_d_r  <= 1'b0;
         xtl_d_r  <= 1'b0;
      end else begin
         irc_s_r  <= {irc_s_r[0], internal_trimmed_clock};
         xtl_s_r  <= {xtl_s_r[0], crystal_clock};
         fail_s_r <= {fail_s_r[0], osc_fail};
         irc_d_r  <= irc_s_r[1];
         xtl_d_r  <= xtl_s_r[1];
      end
   end

   // ***********************************
   // Register bus slave
   // ***********************************
   // One wait cycle, then a single answer cycle
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if (req) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= rdata_nxt;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Read mux, unmapped indices read zero
   always @* begin
      rdata_nxt = 32'h0000_0000;
      case (idx)
         `PLLCG_IDX_SYNTH: rdata_nxt[7:0] = {vco_rng_r, synth_r};
         `PLLCG_IDX_REFDV: rdata_nxt[7:0] = {ref_rng_r, 2'b00, ref_div_r};
         `PLLCG_IDX_POST:  rdata_nxt[4:0] = post_r;
         `PLLCG_IDX_FLAGS: begin
            rdata_nxt[`PLLCG_B_LFLAG] = lflag_r;
            rdata_nxt[`PLLCG_B_LSTAT] = locked;
         end
         `PLLCG_IDX_INTEN: begin
            rdata_nxt[`PLLCG_B_LOCK_CHANGE_IRQ_EN] = lock_ie_r;
            rdata_nxt[`PLLCG_B_OSC_CHANGE_IRQ_EN]  = osc_ie_r;
         end
         `PLLCG_IDX_CLKS: begin
            rdata_nxt[`PLLCG_B_LOOPSEL] = loop_sel_r;
            rdata_nxt[`PLLCG_B_GATING]  = stop_clock_gating;
         end
         `PLLCG_IDX_OSC:   rdata_nxt[`PLLCG_B_OSCEN] = ext_osc_enable;
         `PLLCG_IDX_GUARD: rdata_nxt[0] = guard_r;
         `PLLCG_IDX_OSC2: begin
            rdata_nxt[`PLLCG_B_MONRST] = osc_monitor_reset_en;
            rdata_nxt[`PLLCG_B_SWING]  = osc_swing_select;
         end
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // ***********************************
   // Control registers
   // ***********************************
   // Reset leaves internal reference and 50 MHz target
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         synth_r              <= `PLLCG_SYN_RST;
         vco_rng_r            <= `PLLCG_VRNG_RST;
         ref_div_r            <= 4'h0;
         ref_rng_r            <= 2'h0;
         post_r               <= `PLLCG_POST_RST;
         lock_ie_r            <= 1'b0;
         osc_ie_r             <= 1'b0;
         loop_sel_r           <= 1'b1;
         stop_clock_gating    <= 1'b0;
         ext_osc_enable       <= 1'b0;
         guard_r              <= 1'b0;
         osc_monitor_reset_en <= 1'b0;
         osc_swing_select     <= 1'b0;
      end else begin
         // Any value but the key sets the guard
         if (wr && idx == `PLLCG_IDX_GUARD)
            guard_r <= (wd != `PLLCG_GUARD_KEY);
         if (open_wr && idx == `PLLCG_IDX_SYNTH) begin
            synth_r   <= wd[5:0];
            vco_rng_r <= wd[7:6];
         end
         if (open_wr && idx == `PLLCG_IDX_REFDV) begin
            ref_div_r <= wd[3:0];
            ref_rng_r <= wd[7:6];
         end
         if (open_wr && idx == `PLLCG_IDX_POST)
            post_r <= wd[4:0];
         if (wr && idx == `PLLCG_IDX_INTEN) begin
            lock_ie_r <= wd[`PLLCG_B_LOCK_CHANGE_IRQ_EN];
            osc_ie_r  <= wd[`PLLCG_B_OSC_CHANGE_IRQ_EN];
         end
         // Losing lock hands the bus back to the loop
         if (lock_d_r && !locked)
            loop_sel_r <= 1'b1;
         else if (open_wr && idx == `PLLCG_IDX_CLKS)
            loop_sel_r <= wd[`PLLCG_B_LOOPSEL];
         if (open_wr && idx == `PLLCG_IDX_CLKS)
            stop_clock_gating <= wd[`PLLCG_B_GATING];
         if (open_wr && idx == `PLLCG_IDX_OSC)
            ext_osc_enable <= wd[`PLLCG_B_OSCEN];
         // Both osc2 bits frozen while the oscillator runs
         if (open_wr && loop_sel_r && idx == `PLLCG_IDX_OSC2
             && !ext_osc_enable) begin
            osc_monitor_reset_en <= wd[`PLLCG_B_MONRST];
            osc_swing_select     <= wd[`PLLCG_B_SWING];
         end
      end
   end

   // ***********************************
   // Lock flag and interrupt
   // ***********************************
   // Set beats a same-cycle write-one clear
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         lock_d_r <= 1'b0;
         lflag_r  <= 1'b0;
         lock_irq <= 1'b0;
      end else begin
         lock_d_r <= locked;
         if (lock_chg)
            lflag_r <= 1'b1;
         else if (wr && idx == `PLLCG_IDX_FLAGS && wd[`PLLCG_B_LFLAG])
            lflag_r <= 1'b0;
         lock_irq <= lflag_r & lock_ie_r;
      end
   end

   // ***********************************
   // Oscillator clock monitor
   // ***********************************
   always @(posedge clk_sys) begin
      if (sys_rst)
         osc_monitor_reset <= 1'b0;
      else
         osc_monitor_reset <= ext_osc_enable & osc_monitor_reset_en
                              & fail_s_r[1];
   end

   // ***********************************
   // Reference path
   // ***********************************
   // Internal clock passes undivided
   assign src_tick = ext_osc_enable ? xtl_rise : irc_rise;

   pllcg_divider #(.W(4)) u_ref_divider (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .tick_in  (src_tick),
      .div      (ext_osc_enable ? ref_div_r : 4'h0),
      .tick_out (ref_tick)
   );

   // ***********************************
   // Digital VCO model
   // ***********************************
   // Period steps one count per correction; trades speed for area
   always @* begin
      per_nxt = per_r;
      if (ref_lost)
         per_nxt = vco_floor(vco_rng_r);
      else if (corr_up && per_r > `PLLCG_PER_MIN)
         per_nxt = per_r - 16'h0001;
      else if (corr_dn && per_r < `PLLCG_PER_MAX)
         per_nxt = per_r + 16'h0001;
   end

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         per_r      <= `PLLCG_PER_RST;
         vcnt_r     <= 16'h0000;
         vco_tick_r <= 1'b0;
      end else begin
         per_r      <= per_nxt;
         vco_tick_r <= 1'b0;
         if (vcnt_r >= per_r) begin
            vcnt_r     <= 16'h0000;
            vco_tick_r <= 1'b1;
         end else begin
            vcnt_r <= vcnt_r + 16'h0001;
         end
      end
   end

   // ***********************************
   // Feedback and phase detector
   // ***********************************
   // Half rate of the divider gives the factor two
   pllcg_divider #(.W(6)) u_fbdiv (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .tick_in  (vco_tick_r),
      .div      (synth_r),
      .tick_out (fb_tick)
   );

   // Leading edge sets a pending mark, lagging edge clears it
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         fb_half_r  <= 1'b0;
         ref_pend_r <= 1'b0;
         fb_pend_r  <= 1'b0;
      end else begin
         if (fb_tick)
            fb_half_r <= ~fb_half_r;
         if (corr_up)
            ref_pend_r <= 1'b1;
         else if (fb_edge)
            ref_pend_r <= 1'b0;
         if (corr_dn)
            fb_pend_r <= 1'b1;
         else if (ref_tick)
            fb_pend_r <= 1'b0;
      end
   end

   pllcg_lockdet #(
      .WIN  (LOCK_WIN),
      .TOL  (LOCK_TOL),
      .UTOL (UNL_TOL),
      .LOSS (REF_LOSS)
   ) u_lock (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .ref_tick (ref_tick),
      .fb_edge  (fb_edge),
      .locked   (locked),
      .ref_lost (ref_lost)
   );

   // ***********************************
   // Output divider and bus clock
   // ***********************************
   // Post divider applies only once locked
   pllcg_divider #(.W(5)) u_post (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .tick_in  (vco_tick_r),
      .div      (locked ? post_r : `PLLCG_UNL_DIV),
      .tick_out (pll_tick)
   );

   // Bus clock toggles per source tick, so half rate
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         loop_output_clock <= 1'b0;
         bus_clock         <= 1'b0;
         reference_clock   <= 1'b0;
         feedback_clock    <= 1'b0;
      end else begin
         loop_output_clock <= pll_tick;
         reference_clock   <= ref_tick;
         feedback_clock    <= fb_half_r;
         if (loop_sel_r ? pll_tick : xtl_rise)
            bus_clock <= ~bus_clock;
      end
   end
endmodule // pllcg_top
`default_nettype wire

// ### tb/pllcg_clock_generator_control_tb.sv
// Self-checking bench for the loop clock generator control block.
// Assumes pllcg_top; the bench makes the slow clock pins itself.
`timescale 1ns/100ps
`default_nettype none
module pll_clock_generator_control_tb;
   logic        clk_sys = 0, sys_rst = 1, avs_read = 0, avs_write = 0, osc_fail = 0;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_v, seed = 32'h4b09dbbd;
   logic        avs_waitrequest, loop_output_clock, bus_clock, reference_clock, feedback_clock;
   logic        ext_osc_enable, osc_swing_select, osc_monitor_reset_en, osc_monitor_reset;
   logic        stop_clock_gating, lock_irq, itc_run = 1, cnt_en = 0, fb_q = 0, bus_q = 0;
   logic        internal_trimmed_clock = 0, crystal_clock = 0;
   logic [2:0]  itc_cnt = 3'h0, xt_cnt = 3'h0;
   logic [7:0]  mdl [0:63];
   logic [3:0]  d;
   integer      n_mismatch = 0, num_checks = 0, n_ref, n_loop, n_fb, n_bus, n_xt, i;
   pllcg_top #(.REF_LOSS(16'h0040)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .internal_trimmed_clock(internal_trimmed_clock), .crystal_clock(crystal_clock), .osc_fail(osc_fail),
      .loop_output_clock(loop_output_clock), .bus_clock(bus_clock), .reference_clock(reference_clock),
      .feedback_clock(feedback_clock), .ext_osc_enable(ext_osc_enable), .osc_swing_select(osc_swing_select),
      .osc_monitor_reset_en(osc_monitor_reset_en), .osc_monitor_reset(osc_monitor_reset),
      .stop_clock_gating(stop_clock_gating), .lock_irq(lock_irq));
   // ***
   // Clocks, pins and counters
   // ***
   always #20 clk_sys = ~clk_sys;
   // Slow pins: internal period 8, crystal period 6; internal may stop
   always @(posedge clk_sys) begin
      if (itc_run) begin
         itc_cnt <= itc_cnt + 3'h1;
         internal_trimmed_clock <= itc_cnt[2];
      end
      xt_cnt <= (xt_cnt == 3'h5) ? 3'h0 : xt_cnt + 3'h1;
      crystal_clock <= (xt_cnt >= 3'h3);
   end
   // Event counters over a measuring window
   always @(posedge clk_sys) begin
      fb_q <= feedback_clock;
      bus_q <= bus_clock;
      if (cnt_en) begin
         n_ref += (reference_clock === 1'b1);
         n_loop += (loop_output_clock === 1'b1);
         n_fb += (feedback_clock === 1'b1 && fb_q === 1'b0);
         n_bus += (bus_clock !== bus_q);
         n_xt += (xt_cnt == 3'h3);
      end
   end
   // ***
   // Tasks
   // ***
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic [7:0] msk(input [5:0] x);
      case (x)
         6'h14: msk = 8'hff;
         6'h15: msk = 8'hcf;
         6'h16: msk = 8'h1f;
         6'h18: msk = 8'h12;
         6'h19: msk = 8'h81;
         6'h1a: msk = 8'h80;
         6'h1e: msk = 8'h03;
         default: msk = 8'h00;
      endcase
   endfunction
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task chk_rng(input string nm, input integer lo, input integer hi, input integer g);
      chk(nm, 1, (g >= lo && g <= hi));
   endtask
   // One bus cycle; request held until waitrequest is seen low
   task bus_op(input logic wr, input [5:0] x, input [7:0] v);
      integer k;
      avs_address <= {x, 2'b00};
      avs_writedata <= {24'h0, v};
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && k < 50) begin
         @(posedge clk_sys);
         k++;
      end
      rd_v = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (k >= 50) begin
         chk("bus timeout", 0, 1);
         summarize;
      end
      @(posedge clk_sys);
   endtask
   // Write with the expected register model kept alongside
   task wr(input [5:0] x, input [7:0] v);
      bus_op(1'b1, x, v);
      if (x == 6'h1b) mdl[x] = {7'h0, v != 8'h26};
      else if (x == 6'h1e) begin
         if (!mdl[6'h1b][0] && mdl[6'h19][7] && !mdl[6'h1a][7]) mdl[x] = v & 8'h03;
      end else if (x == 6'h18 || (x != 6'h17 && !mdl[6'h1b][0])) mdl[x] = v & msk(x);
   endtask
   task rd_chk(input [5:0] x);
      bus_op(1'b0, x, 8'h00);
      chk("register", {24'h0, mdl[x]}, rd_v);
   endtask
   task meas(input integer n);
      {n_ref, n_loop, n_fb, n_bus, n_xt} = 0;
      cnt_en = 1;
      repeat (n) @(posedge clk_sys);
      cnt_en = 0;
   endtask
   task wait_lock(input logic want);
      integer k;
      bus_op(1'b0, 6'h17, 8'h00);
      for (k = 0; k < 4000 && rd_v[3] !== want; k++) bus_op(1'b0, 6'h17, 8'h00);
      chk("lock status", want, rd_v[3]);
      if (rd_v[3] !== want) summarize;
   endtask
   // ***
   // Main sequence
   // ***
   initial begin
      for (i = 0; i < 64; i++) mdl[i] = 8'h00;
      mdl[6'h14] = 8'h58;
      mdl[6'h16] = 8'h03;
      mdl[6'h19] = 8'h80;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      // Reset values and unmapped places
      foreach (mdl[j]) if (j != 6'h17) rd_chk(j);
      $display("test reset done");
      // Unlocked: output is VCO over four; bus clock is half of it
      meas(2000);
      chk_rng("unlocked ratio", n_fb * 25 / 2 - 13, n_fb * 25 / 2 + 13, n_loop);
      chk_rng("bus toggles", n_loop - 1, n_loop + 1, n_bus);
      $display("test unlocked done");
      // Guard and loop select gate the second oscillator register
      wr(6'h1b, 8'h55);
      wr(6'h1e, 8'h03);
      rd_chk(6'h1b);
      rd_chk(6'h1e);
      wr(6'h1b, 8'h26);
      wr(6'h19, 8'h00);
      wr(6'h1e, 8'h03);
      rd_chk(6'h1e);
      wr(6'h19, 8'h81);
      seed = lfsr(seed);
      wr(6'h1e, seed[7:0]);
      rd_chk(6'h1e);
      chk("swing", mdl[6'h1e][0], osc_swing_select);
      chk("gating", 1, stop_clock_gating);
      wr(6'h1e, 8'h02);
      $display("test guard done");
      // Oscillator on: mode frozen, monitor reset armed
      wr(6'h1a, 8'h80);
      chk("osc enable", 1, ext_osc_enable);
      wr(6'h1e, 8'h01);
      rd_chk(6'h1e);
      chk("monitor en", 1, osc_monitor_reset_en);
      osc_fail <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk("monitor reset", 1, osc_monitor_reset);
      osc_fail <= 1'b0;
      // Crystal reference divided by ref divider plus one
      seed = lfsr(seed);
      d = {2'b00, seed[1:0]};
      wr(6'h15, {4'h0, d});
      meas(72 * (d + 1));
      chk_rng("crystal ref", n_xt / (d + 1) - 1, n_xt / (d + 1) + 1, n_ref);
      wr(6'h1a, 8'h00);
      meas(80);
      chk_rng("internal ref", 9, 11, n_ref);
      $display("test reference done");
      // Lock with an enabled interrupt, then clear and mask
      wr(6'h18, 8'h12);
      wr(6'h14, 8'h01);
      wr(6'h16, 8'h01);
      wait_lock(1'b1);
      repeat (3) @(posedge clk_sys);
      chk("irq on lock", 1, lock_irq);
      meas(1000);
      chk_rng("locked ratio", 2 * n_fb - 2, 2 * n_fb + 2, n_loop);
      wr(6'h17, 8'h10);
      bus_op(1'b0, 6'h17, 8'h00);
      chk("flag cleared", 8'h08, rd_v);
      chk("irq cleared", 0, lock_irq);
      wr(6'h18, 8'h00);
      rd_chk(6'h18);
      // Reference lost: unlock, flag pends while masked
      itc_run = 0;
      wait_lock(1'b0);
      repeat (3) @(posedge clk_sys);
      chk("irq masked", 0, lock_irq);
      wr(6'h18, 8'h10);
      repeat (2) @(posedge clk_sys);
      chk("irq pending", 1, lock_irq);
      rd_chk(6'h19);
      $display("test lock done");
      summarize;
   end
endmodule // pll_clock_generator_control_tb
`default_nettype wire

// ### tb/pllcg_monitor.sv
// Port checker for the loop clock generator control block.
// Assumes a bind onto pllcg_top; a single clk_sys domain.
`timescale 1ns/100ps
`default_nettype none
module pllcg_monitor (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // Register bus
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Pins and controls
   input wire logic        osc_fail,
   input wire logic        reference_clock,
   input wire logic        ext_osc_enable,
   input wire logic        osc_swing_select,
   input wire logic        osc_monitor_reset_en,
   input wire logic        osc_monitor_reset,
   input wire logic        lock_irq
);
   // ***
   // Properties
   // ***
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_taken; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
   sequence s_armed; (ext_osc_enable && osc_monitor_reset_en && osc_fail) [*6]; endsequence
   property p_wait_answer; s_taken |=> s_answer; endproperty
   property p_no_stray; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
   property p_rd_upper; !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
   property p_rd_hold; avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata); endproperty
   property p_rst_out;
      disable iff (1'b0) sys_rst |=> avs_waitrequest && !lock_irq && !ext_osc_enable && !osc_monitor_reset;
   endproperty
   property p_mon_cause; osc_monitor_reset |-> osc_monitor_reset_en && (ext_osc_enable || $past(ext_osc_enable));
   endproperty
   property p_mon_fire; s_armed |-> osc_monitor_reset; endproperty
   // Swing and monitor fields frozen while the oscillator runs
   property p_osc2_frozen;
      ext_osc_enable && $past(ext_osc_enable) |-> $stable(osc_swing_select) && $stable(osc_monitor_reset_en);
   endproperty
   // Reference pulses are single cycles, pins are slow
   // Switching the reference source may bunch two pulses, so only a steady select counts
   property p_ref_pulse;
      reference_clock && ext_osc_enable == $past(ext_osc_enable, 6)
         |=> (!reference_clock || ext_osc_enable != $past(ext_osc_enable, 6)) [*4];
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("bus answer not one cycle after request");
   a_no_stray: assert property (p_no_stray) else $error("bus answer without request");
   a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits not zero");
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed between answers");
   a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
   a_mon_cause: assert property (p_mon_cause) else $error("monitor reset without enables");
   a_mon_fire: assert property (p_mon_fire) else $error("monitor reset missing on failure");
   a_osc2_frozen: assert property (p_osc2_frozen) else $error("oscillator mode changed while enabled");
   a_ref_pulse: assert property (p_ref_pulse) else $error("reference pulse too wide");
endmodule // pllcg_monitor
bind pllcg_top pllcg_monitor u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .osc_fail(osc_fail), .reference_clock(reference_clock), .ext_osc_enable(ext_osc_enable),
   .osc_swing_select(osc_swing_select), .osc_monitor_reset_en(osc_monitor_reset_en),
   .osc_monitor_reset(osc_monitor_reset), .lock_irq(lock_irq));
`default_nettype wire
